// ---- rtl/flash_host_defs.svh ----
// Purpose: Offsets, fields, command codes and timing counts for the flash host controller
// Assumes: 250 MHz pclk
// Notes:   Definitions only
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// Register byte offsets
`define REG_CTRL    8'h00
`define REG_ADDR    8'h04
`define REG_WDATA   8'h08
`define REG_STATUS  8'h0C
`define REG_RDATA   8'h10
`define REG_BUF     8'h14

// Control field positions
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 3
`define CTRL_START  4
`define CTRL_VPEN   5
`define CTRL_HV     6
`define CTRL_RST    7
`define CTRL_WORD   8
`define CTRL_RESET  9'h000

// Command codes written on the low byte
`define CMD_ARRAY   8'hFF
`define CMD_IDENT   8'h90
`define CMD_QUERY   8'h98
`define CMD_CLRST   8'h50
`define CMD_PROG    8'h40
`define CMD_ERASE   8'h20
`define CMD_CONFIRM 8'hD0
`define CMD_BUFWR   8'hE8
`define CMD_SUSP    8'hB0
`define CMD_LOCK    8'h60
`define CMD_MLOCK   8'hF1

// Buffered write count limits
`define N_MAX_BYTE  5'h1F
`define N_MAX_WORD  5'h0F

// Pin timing, in ns, and derived pclk counts (least times round up)
`define CLK_NS      4
`define T_WP_NS     70
`define T_WPH_NS    30
`define T_ACC_NS    150
`define T_WP_CYC    ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WPH_CYC   ((`T_WPH_NS + `CLK_NS - 1) / `CLK_NS)
`define T_ACC_CYC   ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- rtl/flash_host_pkg.sv ----
// Purpose: Types shared by the flash host controller
// Assumes: Nothing
// Notes:   One-hot bus states
package flash_host_pkg;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_SETUP  = 5'h02,
        ST_STROBE = 5'h04,
        ST_READ   = 5'h08,
        ST_RECOV  = 5'h10
    } bus_state_t;

    typedef enum logic [3:0] {
        OP_ARRAY = 4'h0,
        OP_IDENT = 4'h1,
        OP_QUERY = 4'h2,
        OP_CLRST = 4'h3,
        OP_PROG  = 4'h4,
        OP_ERASE = 4'h5,
        OP_BUFWR = 4'h6,
        OP_MLOCK = 4'h7,
        OP_READ  = 4'h8,
        OP_SUSP  = 4'h9
    } op_t;

    typedef enum logic [1:0] {
        MODE_ARRAY  = 2'h0,
        MODE_IDENT  = 2'h1,
        MODE_QUERY  = 2'h2,
        MODE_STATUS = 2'h3
    } mode_t;

endpackage : flash_host_pkg

// ---- rtl/wbuf_mem.sv ----
// Purpose: Staging memory for buffered write data
// Assumes: One write and one read port, same clock
// Notes:   Read data is registered, one cycle after the address
`timescale 1ns/1ns
`default_nettype none

module wbuf_mem #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 16,
    parameter int AW    = 5
) (
    input  wire logic             pclk,     // Clock
    input  wire logic             wr_en,    // Write strobe
    input  wire logic [AW-1:0]    wr_addr,  // Write index
    input  wire logic [WIDTH-1:0] wr_data,  // Write data
    input  wire logic [AW-1:0]    rd_addr,  // Read index
    output var  logic [WIDTH-1:0] rd_data_r // Registered read data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage and registered read
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_r <= mem[rd_addr];
    end

endmodule : wbuf_mem

`default_nettype wire

// ---- rtl/flash_host_ctrl.sv ----
// Purpose: APB-programmed host that drives a NOR flash command interface
// Assumes: Flash pins synchronous to pclk; device timing met by the counts in the defs header
// Notes:   One operation at a time; software polls status for completion
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defs.svh"

// Notes on behaviour
// RL1 - With program supply low, only reads; every modifying operation is refused.
// RL2 - With program supply high, erase, program and lock operations are also allowed.
// RL3 - Commands are writes of a code at any address; FF array, 50 clear status.
// RL4 - After 90, reads return identifier codes selected by the identifier address.
// RL5 - After 98, reads return query entries selected by the query address.
// RL6 - Program setup is 40 or 10, then address and data follow.
// RL7 - Program data and address are latched on the write strobe rising edge.
// RL8 - Buffered write gives count N, then N+1 data; N to 1F byte, 0F word.
// RL9 - Confirm D0 follows exactly N+1 buffer data writes, then programming starts.
// RL10 - Any other code in the confirm slot aborts the buffered write.
// RL11 - Block erase is 20 then D0 in the block; erasing waits for confirm.
// RL12 - After E8, read extended status and see a free buffer before the count.
// RL13 - Erase or program of a locked block fails without reset-pin override voltage.
// RL14 - Master lock is 60 then F1, performed only with reset-pin override voltage.
// RL15 - Block lock needs override only when the master lock bit is set.
// RL16 - Clear lock bits clears all at once; override needed only if master set.
// RL17 - In sixteen-bit operation the upper byte of command writes is ignored.
// RL18 - While the device is busy, reads give only the ready bit on line 7.
// RL19 - Device enters read array mode at power-up and on leaving reset.
// RL20 - Read array mode holds until another command is written.
// RL21 - Read array is ignored while an operation runs unless erase is suspended.
// RL22 - Read array is accepted at any supply level and either reset-pin level.
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int AW = 24
) (
    input  wire logic          pclk,       // Clock, 250 MHz
    input  wire logic          presetn,    // Async reset, active low
    input  wire logic          psel,       // APB select
    input  wire logic          penable,    // APB enable
    input  wire logic          pwrite,     // APB direction
    input  wire logic [7:0]    paddr,      // APB byte address
    input  wire logic [31:0]   pwdata,     // APB write data
    output var  logic [31:0]   prdata_r,   // APB read data
    output var  logic          pready_r,   // APB ready
    output var  logic          pslverr_r,  // APB error
    output var  logic [AW-1:0] fl_addr_r,  // Flash address
    output var  logic [15:0]   fl_dq_o_r,  // Flash data out
    output var  logic          fl_dq_oe_r, // Flash data drive enable
    input  wire logic [15:0]   fl_dq_i,    // Flash data in
    output var  logic          fl_ce_n_r,  // Chip enable, low active
    output var  logic          fl_we_n_r,  // Write strobe, low active
    output var  logic          fl_oe_n_r,  // Output enable, low active
    output var  logic          reset_powerdown_pin_n_r, // Reset/power-down, low active
    output var  logic          override_high_voltage_r, // Request override level on reset pin
    output var  logic          program_enable_supply_r, // Switch program supply to high level
    output var  logic          fl_word_r   // Sixteen-bit bus select
);
    import flash_host_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register and sequencer state
    logic [8:0]    ctrl_r, ctrl_nxt;
    logic [AW-1:0] addr_r, addr_nxt;
    logic [15:0]   wdata_r, wdata_nxt;
    logic [15:0]   rdata_r, rdata_nxt;
    logic [4:0]    bufptr_r, bufptr_nxt;
    logic          go_r, go_nxt, refused_r, refused_nxt, xsr_ok_r, xsr_ok_nxt;
    logic [31:0]   prdata_nxt;
    logic          pready_nxt, pslverr_nxt;
    bus_state_t    st_r, st_nxt;
    op_t           op_r, op_nxt;
    mode_t         mode_r, mode_nxt;
    logic [2:0]    step_r, step_nxt;
    logic [5:0]    cnt_r, cnt_nxt, tmr_r, tmr_nxt;
    logic [AW-1:0] fl_addr_nxt;
    logic [15:0]   fl_dq_o_nxt, buf_rd;
    logic          fl_dq_oe_nxt, fl_ce_n_nxt, fl_we_n_nxt, fl_oe_n_nxt;
    logic          busy, buf_we, cyc_rd, cyc_last, modifying;
    logic [7:0]    cyc_code;
    logic [4:0]    n_cnt;

    assign busy  = (st_r != ST_IDLE) || go_r;
    assign n_cnt = wdata_r[4:0];

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: ready one cycle into the access phase, write at the ready edge
    always_comb begin
        ctrl_nxt    = ctrl_r;
        addr_nxt    = addr_r;
        wdata_nxt   = wdata_r;
        bufptr_nxt  = bufptr_r;
        go_nxt      = 1'b0;
        buf_we      = 1'b0;
        pready_nxt  = 1'b0;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel && penable && !pready_r) begin
            pready_nxt = 1'b1;
            prdata_nxt = 32'h0000_0000;
            case (paddr)
                `REG_CTRL:   prdata_nxt = {23'h0, ctrl_r};
                `REG_ADDR:   prdata_nxt = 32'(addr_r);
                `REG_WDATA:  prdata_nxt = {16'h0, wdata_r};
                `REG_STATUS: prdata_nxt = {24'h0, bufptr_r[2:0], mode_r, xsr_ok_r, refused_r, busy};
                `REG_RDATA:  prdata_nxt = {16'h0, rdata_r};
                `REG_BUF:    prdata_nxt = {27'h0, bufptr_r};
                default:     pslverr_nxt = 1'b1;
            endcase
            // Start while busy is answered with an error and dropped
            if (pwrite && paddr == `REG_CTRL && pwdata[`CTRL_START] && busy) begin
                pslverr_nxt = 1'b1;
            end
        end else if (psel && penable && pready_r && pwrite && !pslverr_r) begin
            case (paddr)
                `REG_CTRL: begin
                    ctrl_nxt = pwdata[8:0] & 9'h1EF;
                    go_nxt   = pwdata[`CTRL_START];
                end
                `REG_ADDR:  addr_nxt  = pwdata[AW-1:0];
                `REG_WDATA: wdata_nxt = pwdata[15:0];
                `REG_BUF: begin
                    buf_we     = 1'b1;
                    bufptr_nxt = bufptr_r + 5'h01;
                end
                default: ;
            endcase
        end
        // A finished buffered write rewinds the staging pointer
        if (st_r == ST_RECOV && op_r == OP_BUFWR && cyc_last && tmr_r == 6'h00) begin
            bufptr_nxt = 5'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r    <= `CTRL_RESET;
            addr_r    <= '0;
            wdata_r   <= 16'h0000;
            bufptr_r  <= 5'h00;
            go_r      <= 1'b0;
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            addr_r    <= addr_nxt;
            wdata_r   <= wdata_nxt;
            bufptr_r  <= bufptr_nxt;
            go_r      <= go_nxt;
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Buffered write data staging
    wbuf_mem #(.DEPTH(32), .WIDTH(16), .AW(5)) u_wbuf (
        .pclk      (pclk),
        .wr_en     (buf_we),
        .wr_addr   (bufptr_r),
        .wr_data   (pwdata[15:0]),
        .rd_addr   (cnt_nxt[4:0]),   // Ahead of cnt_r, word ready at setup
        .rd_data_r (buf_rd)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // What the current bus cycle is, from operation and step
    always_comb begin
        cyc_rd   = 1'b0;
        cyc_last = 1'b1;
        cyc_code = `CMD_ARRAY;
        case (op_r)
            OP_ARRAY: cyc_code = `CMD_ARRAY;                          // see RL3
            OP_CLRST: cyc_code = `CMD_CLRST;                          // see RL3
            OP_SUSP:  cyc_code = `CMD_SUSP;
            OP_READ:  cyc_rd   = 1'b1;
            OP_IDENT: begin                                           // see RL4
                cyc_code = `CMD_IDENT;
                cyc_rd   = (step_r != 3'd0);
                cyc_last = (step_r != 3'd0);
            end
            OP_QUERY: begin                                           // see RL5
                cyc_code = `CMD_QUERY;
                cyc_rd   = (step_r != 3'd0);
                cyc_last = (step_r != 3'd0);
            end
            OP_PROG: begin                                            // see RL6
                cyc_code = (step_r == 3'd0) ? `CMD_PROG : wdata_r[7:0];
                cyc_last = (step_r != 3'd0);
            end
            OP_ERASE: begin                                           // see RL11
                cyc_code = (step_r == 3'd0) ? `CMD_ERASE : `CMD_CONFIRM;
                cyc_last = (step_r != 3'd0);
            end
            OP_MLOCK: begin                                           // see RL14
                cyc_code = (step_r == 3'd0) ? `CMD_LOCK : `CMD_MLOCK;
                cyc_last = (step_r != 3'd0);
            end
            OP_BUFWR: begin                                           // see RL8
                cyc_rd   = (step_r == 3'd1);
                cyc_last = (step_r == 3'd4);
                cyc_code = (step_r == 3'd0) ? `CMD_BUFWR :
                           (step_r == 3'd2) ? {3'h0, n_cnt} : `CMD_CONFIRM;
            end
            default: ;
        endcase
    end

    // Operations that change the array or lock bits
    assign modifying = (op_t'(ctrl_r[3:0]) inside {OP_PROG, OP_ERASE, OP_BUFWR, OP_MLOCK});

    ////////////////////////////////////////////////////////////////////////////////
    // Pin sequencer: setup, strobe or read access, recovery
    always_comb begin
        st_nxt = st_r;  op_nxt = op_r;  step_nxt = step_r;  cnt_nxt = cnt_r;
        tmr_nxt = tmr_r;  mode_nxt = mode_r;  rdata_nxt = rdata_r;
        refused_nxt = refused_r;  xsr_ok_nxt = xsr_ok_r;
        fl_addr_nxt = fl_addr_r;  fl_dq_o_nxt = fl_dq_o_r;  fl_dq_oe_nxt = fl_dq_oe_r;
        fl_ce_n_nxt = fl_ce_n_r;  fl_we_n_nxt = fl_we_n_r;  fl_oe_n_nxt = fl_oe_n_r;
        case (st_r)
            ST_IDLE: begin
                if (go_r) begin
                    op_nxt      = op_t'(ctrl_r[3:0]);
                    step_nxt    = 3'd0;
                    cnt_nxt     = 6'h00;
                    xsr_ok_nxt  = 1'b0;
                    refused_nxt = 1'b0;
                    // Refuse modifying work without the high supply (see RL1, RL2),
                    // master lock without override (see RL14), an oversize count (see RL8),
                    // and anything while the device is held in reset
                    if ((modifying && !ctrl_r[`CTRL_VPEN]) || ctrl_r[`CTRL_RST] ||
                        (ctrl_r[3:0] == OP_MLOCK && !ctrl_r[`CTRL_HV]) ||
                        (ctrl_r[3:0] == OP_BUFWR &&
                         n_cnt > (ctrl_r[`CTRL_WORD] ? `N_MAX_WORD : `N_MAX_BYTE)) ||
                        ctrl_r[3:0] > OP_SUSP) begin
                        refused_nxt = 1'b1;
                    end else begin
                        st_nxt = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                fl_ce_n_nxt = 1'b0;
                fl_addr_nxt = addr_r + ((op_r == OP_BUFWR && step_r == 3'd3) ? AW'(cnt_r) : '0);
                if (cyc_rd) begin
                    fl_dq_oe_nxt = 1'b0;
                    fl_oe_n_nxt  = 1'b0;
                    tmr_nxt      = 6'(`T_ACC_CYC - 1);
                    st_nxt       = ST_READ;
                end else begin
                    // Upper byte zero on command writes (see RL17); data words pass whole
                    fl_dq_o_nxt  = {8'h00, cyc_code};                      // see RL3
                    if (op_r == OP_PROG && step_r == 3'd1) begin
                        fl_dq_o_nxt = wdata_r;                             // see RL7
                    end
                    if (op_r == OP_BUFWR && step_r == 3'd3) begin
                        fl_dq_o_nxt = buf_rd;
                    end
                    fl_dq_oe_nxt = 1'b1;
                    fl_we_n_nxt  = 1'b0;
                    tmr_nxt      = 6'(`T_WP_CYC - 1);
                    st_nxt       = ST_STROBE;
                end
            end
            ST_STROBE: begin
                tmr_nxt = tmr_r - 6'h01;
                if (tmr_r == 6'h00) begin
                    // Rising strobe edge latches address and data in the device (see RL7)
                    fl_we_n_nxt = 1'b1;
                    tmr_nxt     = 6'(`T_WPH_CYC - 1);
                    st_nxt      = ST_RECOV;
                    // Track device read mode (see RL20)
                    case (cyc_code)
                        `CMD_ARRAY: mode_nxt = MODE_ARRAY;
                        `CMD_IDENT: mode_nxt = MODE_IDENT;
                        `CMD_QUERY: mode_nxt = MODE_QUERY;
                        default:    mode_nxt = MODE_STATUS;
                    endcase
                end
            end
            ST_READ: begin
                tmr_nxt = tmr_r - 6'h01;
                if (tmr_r == 6'h00) begin
                    rdata_nxt = ctrl_r[`CTRL_WORD] ? fl_dq_i : {8'h00, fl_dq_i[7:0]};
                    // Status poll: only line 7 is driven while busy (see RL18, RL12)
                    if (op_r == OP_BUFWR) begin
                        xsr_ok_nxt = fl_dq_i[7];
                    end
                    fl_oe_n_nxt = 1'b1;
                    tmr_nxt     = 6'(`T_WPH_CYC - 1);
                    st_nxt      = ST_RECOV;
                end
            end
            ST_RECOV: begin
                tmr_nxt = tmr_r - 6'h01;
                if (tmr_r == 6'h00) begin
                    fl_ce_n_nxt  = 1'b1;
                    fl_dq_oe_nxt = 1'b0;
                    st_nxt       = cyc_last ? ST_IDLE : ST_SETUP;
                    step_nxt     = step_r + 3'd1;
                    if (op_r == OP_BUFWR && step_r == 3'd1 && !xsr_ok_r) begin
                        step_nxt = 3'd0;                                   // see RL12
                    end
                    if (op_r == OP_BUFWR && step_r == 3'd3) begin
                        cnt_nxt = cnt_r + 6'h01;
                        // Confirm only after exactly N+1 data words (see RL9, RL10)
                        step_nxt = (cnt_r[4:0] == n_cnt) ? 3'd4 : 3'd3;
                    end
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        // Holding the device in reset returns it to array mode (see RL19)
        if (ctrl_r[`CTRL_RST]) begin
            mode_nxt = MODE_ARRAY;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_IDLE;  op_r <= OP_ARRAY;  mode_r <= MODE_ARRAY;
            step_r <= 3'd0;  cnt_r <= 6'h00;  tmr_r <= 6'h00;  rdata_r <= 16'h0000;
            refused_r <= 1'b0;  xsr_ok_r <= 1'b0;
            fl_addr_r <= '0;  fl_dq_o_r <= 16'h0000;  fl_dq_oe_r <= 1'b0;
            fl_ce_n_r <= 1'b1;  fl_we_n_r <= 1'b1;  fl_oe_n_r <= 1'b1;
            reset_powerdown_pin_n_r <= 1'b0;  override_high_voltage_r <= 1'b0;
            program_enable_supply_r <= 1'b0;  fl_word_r <= 1'b0;
        end else begin
            st_r <= st_nxt;  op_r <= op_nxt;  mode_r <= mode_nxt;
            step_r <= step_nxt;  cnt_r <= cnt_nxt;  tmr_r <= tmr_nxt;  rdata_r <= rdata_nxt;
            refused_r <= refused_nxt;  xsr_ok_r <= xsr_ok_nxt;
            fl_addr_r <= fl_addr_nxt;  fl_dq_o_r <= fl_dq_o_nxt;  fl_dq_oe_r <= fl_dq_oe_nxt;
            fl_ce_n_r <= fl_ce_n_nxt;  fl_we_n_r <= fl_we_n_nxt;  fl_oe_n_r <= fl_oe_n_nxt;
            reset_powerdown_pin_n_r <= !ctrl_r[`CTRL_RST];
            override_high_voltage_r <= ctrl_r[`CTRL_HV];
            program_enable_supply_r <= ctrl_r[`CTRL_VPEN];
            fl_word_r               <= ctrl_r[`CTRL_WORD];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the pin sequence
    a_cmd_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // see RL17
        (!fl_we_n_r && op_r != OP_PROG && !(op_r == OP_BUFWR && step_r == 3'd3)) |-> fl_dq_o_r[15:8] == 8'h00)
        else $error("command write drives upper byte");
    a_modify_needs_supply: assert property (@(posedge pclk) disable iff (!presetn) // see RL1
        ($fell(fl_we_n_r) && op_r inside {OP_PROG, OP_ERASE, OP_BUFWR, OP_MLOCK}) |-> program_enable_supply_r)
        else $error("modifying write without high program supply");
    a_mlock_override: assert property (@(posedge pclk) disable iff (!presetn) // see RL14
        (!fl_we_n_r && op_r == OP_MLOCK && step_r == 3'd1) |-> fl_dq_o_r[7:0] == `CMD_MLOCK && override_high_voltage_r)
        else $error("master lock confirm without override");
    a_erase_confirm: assert property (@(posedge pclk) disable iff (!presetn) // see RL11
        (!fl_we_n_r && op_r == OP_ERASE && step_r == 3'd1) |-> fl_dq_o_r[7:0] == `CMD_CONFIRM && fl_addr_r == addr_r)
        else $error("erase confirm wrong code or block");
    a_buf_exact_count: assert property (@(posedge pclk) disable iff (!presetn) // see RL9
        (st_r == ST_SETUP && op_r == OP_BUFWR && step_r == 3'd4) |-> cnt_r == 6'(n_cnt) + 6'h01)
        else $error("buffer confirm after wrong number of data writes");
    a_buf_word_limit: assert property (@(posedge pclk) disable iff (!presetn) // see RL8
        (st_r == ST_SETUP && op_r == OP_BUFWR && step_r == 3'd2 && fl_word_r) |-> n_cnt <= `N_MAX_WORD)
        else $error("word mode count above limit");
    a_buf_after_xsr: assert property (@(posedge pclk) disable iff (!presetn) // see RL12
        (op_r == OP_BUFWR && $changed(step_r) && step_r == 3'd2) |-> xsr_ok_r)
        else $error("count sent before buffer available");
    a_strobe_width: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
        $fell(fl_we_n_r) |-> !fl_we_n_r ##17 !fl_we_n_r ##1 fl_we_n_r)
        else $error("write strobe width wrong");
    a_reset_array: assert property (@(posedge pclk) disable iff (!presetn) // see RL19
        ctrl_r[`CTRL_RST] |=> mode_r == MODE_ARRAY)
        else $error("mode not array under device reset");
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_r) |=> pready_r ##1 !pready_r)
        else $error("apb ready not a single cycle after access");

endmodule : flash_host_ctrl

`default_nettype wire

// ---- tb/flash_dev_model.sv ----
// Purpose: Flash device model
// Assumes: Pins move on pclk
// Notes:   Busy 512 cycles after a program
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model #(
    parameter logic [15:0] ID_CODE = 16'h00A5 // Arbitrary value
) (
    input  wire logic        pclk,        // Clock
    input  wire logic [23:0] addr,        // Address
    input  wire logic [15:0] dq_in,       // Host data
    input  wire logic        ce_n,        // Enable
    input  wire logic        we_n,        // Write strobe
    input  wire logic        oe_n,        // Read strobe
    input  wire logic        rst_pin_n,   // Reset pin
    input  wire logic        supply,      // Supply high
    output var  logic [15:0] dq_out       // Device data
);
    logic [1:0]  mode = 2'h0;
    logic [7:0]  cmd = 8'hFF;
    logic [15:0] prog_data = 16'h0, busy = 16'h0;
    logic [23:0] prog_addr = 24'h0;
    logic [31:0] hist = 32'h0;
    logic        we_d = 1'b1;
    // Commands taken on the rising strobe
    always @(posedge pclk) begin
        we_d <= we_n;
        busy <= (busy != 16'h0) ? busy - 16'h1 : busy;
        if (!rst_pin_n) begin
            mode <= 2'h0;
        end else if (we_n && !we_d && !ce_n) begin
            cmd <= dq_in[7:0];
            hist <= {hist[15:0], dq_in};
            if ((cmd == 8'h40 || cmd == 8'h10) && supply) begin
                prog_data <= dq_in;
                prog_addr <= addr;
                busy <= 16'h0200;
            end else if (dq_in[7:0] != 8'hFF) begin
                mode <= (dq_in[7:0] == 8'h90) ? 2'h1 : (dq_in[7:0] == 8'h98) ? 2'h2 : 2'h3;
            end else if (busy == 16'h0) begin
                mode <= 2'h0;
            end
        end
    end
    // Floated lines show a changing pattern
    assign dq_out = (oe_n || ce_n) ? ~addr[15:0] : (busy != 16'h0) ? {busy[7:0], 1'b0, busy[14:8]}
        : (mode == 2'h0) ? addr[15:0] ^ 16'h3C3C : (mode == 2'h1) ? ID_CODE
        : (mode == 2'h2) ? {8'h00, addr[7:0] + 8'h41} : 16'h0080;
endmodule : flash_dev_model
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Bench for the flash host
// Assumes: Word mode
// Notes:   Model on the pins
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defs.svh"
module tb;
    import flash_host_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready_r, pslverr_r, ce_n, we_n, oe_n, rst_n, sup, e;
    logic [31:0] pwdata, prdata_r, q, st;
    logic [23:0] fa;
    logic [15:0] dqo, dqi;
    logic [7:0]  paddr;
    int          num_errors = 0, comparisons = 0;
    flash_host_ctrl i_flash_host_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_r,
        .pready_r, .pslverr_r, .fl_addr_r(fa), .fl_dq_o_r(dqo), .fl_dq_oe_r(), .fl_dq_i(dqi), .fl_ce_n_r(ce_n),
        .fl_we_n_r(we_n), .fl_oe_n_r(oe_n), .reset_powerdown_pin_n_r(rst_n), .override_high_voltage_r(),
        .program_enable_supply_r(sup), .fl_word_r());
    flash_dev_model i_flash_dev_model (.pclk, .addr(fa), .dq_in(dqo), .ce_n, .we_n, .oe_n,
        .rst_pin_n(rst_n), .supply(sup), .dq_out(dqi));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; answer taken where pready is high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_r !== 1'b1 && ++n < 40);
        if (pready_r !== 1'b1) num_errors++;
        q = prdata_r;
        e = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Start an operation, poll until idle, fetch read data
    task automatic run(input logic [3:0] op, input logic [8:0] ctl);
        int n;
        n = 0;
        apb(1'b1, `REG_CTRL, {23'h0, ctl | 9'h010 | {5'h0, op}});
        do apb(1'b0, `REG_STATUS, 32'h0); while (q[0] !== 1'b0 && ++n < 200);
        if (q[0] !== 1'b0) num_errors++;
        st = q;
        apb(1'b0, `REG_RDATA, 32'h0);
    endtask : run
    task automatic end_of_test();
        $display("Errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Watchdog
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `REG_ADDR, 32'h0000_1234);
        run(OP_READ, 9'h100);
        chk(q, 32'h0000_2E08);
        run(OP_IDENT, 9'h100);
        chk(q, 32'h0000_00A5);
        run(OP_ARRAY, 9'h100);
        run(OP_READ, 9'h100);
        chk(q, 32'h0000_2E08);
        apb(1'b1, `REG_ADDR, 32'h0000_0010);
        run(OP_QUERY, 9'h100);
        chk(q, 32'h0000_0051);
        run(OP_READ, 9'h180);
        run(OP_READ, 9'h100);
        chk(q, 32'h0000_3C2C);
        apb(1'b1, `REG_ADDR, 32'h0000_0ABC);
        apb(1'b1, `REG_WDATA, 32'h0000_BEEF);
        run(OP_PROG, 9'h100);
        chk({31'h0, st[1]}, 32'h1);
        run(OP_PROG, 9'h120);
        chk({15'h0, i_flash_dev_model.prog_data, 1'b0}, 32'h0001_7DDE);
        chk({8'h0, i_flash_dev_model.prog_addr}, 32'h0000_0ABC);
        run(OP_ARRAY, 9'h120);
        run(OP_READ, 9'h120);
        chk({31'h0, q[7]}, 32'h0);
        repeat (600) @(posedge pclk);
        run(OP_ARRAY, 9'h120);
        run(OP_READ, 9'h120);
        chk(q, 32'h0000_3680);
        apb(1'b1, `REG_WDATA, 32'h0000_0010);
        run(OP_BUFWR, 9'h120);
        chk({31'h0, st[1]}, 32'h1);
        apb(1'b1, `REG_WDATA, 32'h0000_0001);
        apb(1'b1, `REG_BUF, 32'h0000_1111);
        apb(1'b1, `REG_BUF, 32'h0000_2222);
        run(OP_BUFWR, 9'h120);
        chk({24'h0, st[7:0]}, 32'h0000_001C);
        chk(i_flash_dev_model.hist, 32'h2222_00D0);
        run(OP_MLOCK, 9'h120);
        chk({31'h0, st[1]}, 32'h1);
        run(OP_MLOCK, 9'h160);
        chk(i_flash_dev_model.hist, 32'h0060_00F1);
        run(OP_ERASE, 9'h120);
        chk(i_flash_dev_model.hist, 32'h0020_00D0);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, e}, 32'h1);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
